/* core/ccs_conv_ctrl.sv */
// Start/stop command logic for two current converters and the sequencer,
// plus the read-only step 0 result register.
// Assumes register writes arrive already decoded from command frames,
// one frame per REG_WR_I cycle, and that converters report completions.
`timescale 1ns/1ps

module ccs_conv_ctrl #(
	parameter int ADDR_W = ccs_pkg::CCS_ADDR_W,
	parameter int DATA_W = ccs_pkg::CCS_DATA_W
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	// Register access port
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic [DATA_W-1:0] REG_WDATA_I,
	output logic [DATA_W-1:0] REG_RDATA_O,
	output logic REG_RVALID_O,
	// Current converter status, bit 0 channel A, bit 1 channel B
	input wire logic [1:0] CONV_ENABLE_I,
	input wire logic [1:0] CONV_SINGLE_I,
	input wire logic [1:0] CONV_DONE_I,
	// Sequencer status
	input wire logic SEQ_DONE_I,
	input wire logic STEP0_VALID_I,
	input wire logic [DATA_W-1:0] STEP0_DATA_I,
	// Request pulses, bit 0 A, bit 1 B, bit 2 sequencer
	output logic [2:0] CONV_GO_O,
	output logic [2:0] CONV_HALT_O
);

	localparam int NCH = ccs_pkg::CCS_NCHAN;

	ccs_pkg::ccs_reg_req_type req;
	ccs_pkg::ccs_chan_in_type chan_in [NCH];
	ccs_pkg::ccs_cmd_type cmd [NCH];
	ccs_pkg::ccs_state_type state_q [NCH];
	ccs_pkg::ccs_state_type state_d [NCH];
	logic [NCH-1:0] pending;
	logic [NCH-1:0] go_q;
	logic [NCH-1:0] halt_q;
	logic ctrl_wr;
	logic [DATA_W-1:0] ctrl_rd;
	logic [DATA_W-1:0] step0_value;
	logic [DATA_W-1:0] rdata_q;
	logic rvalid_q;

	// Bundle the access and the converter status
	assign req = {REG_WR_I, REG_RD_I, REG_ADDR_I, REG_WDATA_I};
	assign ctrl_wr = req.wr && ccs_pkg::ccs_hit(req.addr, ccs_pkg::CCS_CTRL_ADDR);
	assign chan_in[ccs_pkg::CCS_CH_A] = {CONV_ENABLE_I[0], CONV_SINGLE_I[0], CONV_DONE_I[0]};
	assign chan_in[ccs_pkg::CCS_CH_B] = {CONV_ENABLE_I[1], CONV_SINGLE_I[1], CONV_DONE_I[1]};
	// Sequencer is always armed and never single-shot
	assign chan_in[ccs_pkg::CCS_CH_SEQ] = {1'b1, 1'b0, SEQ_DONE_I};

	// One identical control slice per channel
	for (genvar g = 0; g < NCH; g++) begin : g_chan
		localparam int GO_B = ccs_pkg::CCS_GO_POS[g];
		localparam int HALT_B = ccs_pkg::CCS_HALT_POS[g];

		assign cmd[g].go = ctrl_wr && req.wdata[GO_B] && chan_in[g].enable;
		// single-shot ignores stop
		// Halt only means something while conversions are running
		assign cmd[g].halt = ctrl_wr && req.wdata[HALT_B] && !req.wdata[GO_B]
			&& !chan_in[g].single && (state_q[g] == ccs_pkg::CCS_RUN);

		// Next run state
		always_comb begin
			state_d[g] = state_q[g];
			case (state_q[g])
				ccs_pkg::CCS_IDLE: begin
					if (cmd[g].go) begin
						state_d[g] = ccs_pkg::CCS_RUN;
					end
				end
				ccs_pkg::CCS_RUN: begin
					// start is taken first, then stop, then done
					// Halt beats a same-cycle done: set wins over clear
					if (cmd[g].go) begin
						state_d[g] = ccs_pkg::CCS_RUN;
					end else if (cmd[g].halt) begin
						state_d[g] = ccs_pkg::CCS_DRAIN;
					end else if (chan_in[g].done && chan_in[g].single) begin
						state_d[g] = ccs_pkg::CCS_IDLE;
					end
				end
				ccs_pkg::CCS_DRAIN: begin
					if (cmd[g].go) begin
						state_d[g] = ccs_pkg::CCS_RUN;
					end else if (chan_in[g].done) begin
						state_d[g] = ccs_pkg::CCS_IDLE;
					end
				end
				default: begin
					state_d[g] = ccs_pkg::CCS_IDLE;
				end
			endcase
		end

		always_ff @(posedge CLOCK_I) begin
			if (!RSTN_I) begin
				state_q[g] <= ccs_pkg::CCS_IDLE;
			end else begin
				state_q[g] <= state_d[g];
			end
		end

		// command bits become pulses
		// Registered so the converters see clean single-cycle requests
		always_ff @(posedge CLOCK_I) begin
			if (!RSTN_I) begin
				go_q[g] <= 1'b0;
				halt_q[g] <= 1'b0;
			end else begin
				go_q[g] <= cmd[g].go;
				halt_q[g] <= cmd[g].halt;
			end
		end

		// The stored stop bit is the draining state itself
		assign pending[g] = (state_q[g] == ccs_pkg::CCS_DRAIN);
	end

	assign CONV_GO_O = go_q;
	assign CONV_HALT_O = halt_q;

	// control readback, start bits zero
	// Start bits are never stored, so they cannot read back as one
	always_comb begin
		ctrl_rd = ccs_pkg::CCS_CTRL_RESET;
		for (int i = 0; i < NCH; i++) begin
			ctrl_rd[ccs_pkg::CCS_HALT_POS[i]] = pending[i];
		end
	end

	ccs_result_reg #(
		.WIDTH(DATA_W),
		.RESET_VALUE(ccs_pkg::CCS_STEP0_RESET)
	) u_step0 (
		.clk_i(CLOCK_I),
		.rstn_i(RSTN_I),
		.load_i(STEP0_VALID_I),
		.data_i(STEP0_DATA_I),
		.value_o(step0_value)
	);

	// register read decode
	// Unmapped addresses answer zero rather than stale data
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			rdata_q <= ccs_pkg::CCS_READ_NONE;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req.rd;
			if (req.rd) begin
				if (ccs_pkg::ccs_hit(req.addr, ccs_pkg::CCS_CTRL_ADDR)) begin
					rdata_q <= ctrl_rd;
				end else if (ccs_pkg::ccs_hit(req.addr, ccs_pkg::CCS_STEP0_ADDR)) begin
					rdata_q <= step0_value;
				end else begin
					rdata_q <= ccs_pkg::CCS_READ_NONE;
				end
			end
		end
	end

	assign REG_RDATA_O = rdata_q;
	assign REG_RVALID_O = rvalid_q;

	// Checks on the command logic
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RSTN_I);

	localparam int GA = ccs_pkg::CCS_GO_POS[ccs_pkg::CCS_CH_A];
	localparam int GB = ccs_pkg::CCS_GO_POS[ccs_pkg::CCS_CH_B];
	localparam int GS = ccs_pkg::CCS_GO_POS[ccs_pkg::CCS_CH_SEQ];
	localparam int HA = ccs_pkg::CCS_HALT_POS[ccs_pkg::CCS_CH_A];
	localparam int HB = ccs_pkg::CCS_HALT_POS[ccs_pkg::CCS_CH_B];
	localparam int HS = ccs_pkg::CCS_HALT_POS[ccs_pkg::CCS_CH_SEQ];

	a_start_chan_a: assert property (ctrl_wr && REG_WDATA_I[GA] |=>
		CONV_GO_O[0] == $past(CONV_ENABLE_I[0]))
		else $error("channel A start not gated by enable");

	a_start_chan_b: assert property (ctrl_wr && REG_WDATA_I[GB] && CONV_ENABLE_I[1] |=>
		CONV_GO_O[1] && state_q[1] == ccs_pkg::CCS_RUN)
		else $error("channel B start did not run");

	a_halt_drain_a: assert property (state_q[0] == ccs_pkg::CCS_RUN && ctrl_wr
		&& REG_WDATA_I[HA] && !REG_WDATA_I[GA] && !CONV_SINGLE_I[0]
		|=> CONV_HALT_O[0] && pending[0] ##1 !CONV_HALT_O[0])
		else $error("channel A stop not held pending");

	a_halt_drain_b: assert property (pending[1] && !CONV_DONE_I[1] && !ctrl_wr |=>
		pending[1])
		else $error("channel B stop ended before done");

	// single-shot stop ignored
	// A stop already pending from continuous mode may still be draining
	a_single_ignore: assert property (ctrl_wr && REG_WDATA_I[HA] && CONV_SINGLE_I[0] |=>
		!CONV_HALT_O[0] && (!pending[0] || $past(pending[0])))
		else $error("stop acted in single-shot mode");

	a_go_beats_halt: assert property (ctrl_wr && REG_WDATA_I[GA] && REG_WDATA_I[HA]
		&& CONV_ENABLE_I[0] |=> CONV_GO_O[0] && !CONV_HALT_O[0] && !pending[0])
		else $error("stop not overridden by start");

	a_drain_clear_a: assert property (pending[0] && CONV_DONE_I[0] && !ctrl_wr |=>
		state_q[0] == ccs_pkg::CCS_IDLE)
		else $error("channel A stop not cleared on done");

	a_restart_clear: assert property (pending[1] && ctrl_wr && REG_WDATA_I[GB]
		&& CONV_ENABLE_I[1] |=> !pending[1] && CONV_GO_O[1])
		else $error("restart did not clear channel B stop");

	a_seq_start: assert property (ctrl_wr && REG_WDATA_I[GS] |=> CONV_GO_O[2])
		else $error("sequence start not issued");

	a_seq_halt: assert property (state_q[2] == ccs_pkg::CCS_RUN && ctrl_wr
		&& REG_WDATA_I[HS] && !REG_WDATA_I[GS] |=> pending[2] && CONV_HALT_O[2])
		else $error("sequence stop not taken");

	a_seq_priority: assert property (ctrl_wr && REG_WDATA_I[GS] && REG_WDATA_I[HS] |=>
		!CONV_HALT_O[2] && !pending[2])
		else $error("sequence stop beat start");

	a_seq_clear: assert property (pending[2] && SEQ_DONE_I && !ctrl_wr |=> !pending[2])
		else $error("sequence stop stuck after finish");

	// reserved and start bits read zero
	a_ctrl_readzero: assert property (REG_RD_I
		&& ccs_pkg::ccs_hit(REG_ADDR_I, ccs_pkg::CCS_CTRL_ADDR)
		|=> REG_RVALID_O && (REG_RDATA_O & ~ccs_pkg::CCS_CTRL_RMASK) == '0)
		else $error("unused control bit read as one");

	a_reset_clear: assert property (disable iff (1'b0) !RSTN_I |=>
		CONV_GO_O == '0 && CONV_HALT_O == '0 && pending == '0)
		else $error("command state not cleared by reset");

	a_step0_read: assert property (STEP0_VALID_I ##1 (REG_RD_I && !STEP0_VALID_I
		&& ccs_pkg::ccs_hit(REG_ADDR_I, ccs_pkg::CCS_STEP0_ADDR))
		|=> REG_RDATA_O == $past(STEP0_DATA_I, 2))
		else $error("step 0 result mismatch");

	a_ctrl_read_pend: assert property (REG_RD_I
		&& ccs_pkg::ccs_hit(REG_ADDR_I, ccs_pkg::CCS_CTRL_ADDR)
		|=> REG_RDATA_O[HB] == $past(pending[1]))
		else $error("channel B stop bit readback wrong");

	a_pulse_cause: assert property (CONV_GO_O[0] |->
		$past(ctrl_wr && REG_WDATA_I[GA] && CONV_ENABLE_I[0]))
		else $error("channel A start pulse without write");

endmodule // ccs_conv_ctrl

/* core/ccs_pkg.sv */
// Shared constants and types for the conversion start/stop control block.
// Assumes a single system clock and a decoded register access port upstream.
package ccs_pkg;

	// Register port geometry
	localparam int CCS_ADDR_W = 8;
	localparam int CCS_DATA_W = 16;

	// Channel indices: two current converters and the sequencer
	localparam int CCS_NCHAN = 3;
	localparam int CCS_CH_A = 0;
	localparam int CCS_CH_B = 1;
	localparam int CCS_CH_SEQ = 2;

	// Register map
	localparam logic [7:0] CCS_CTRL_ADDR = 8'h09;
	localparam logic [7:0] CCS_STEP0_ADDR = 8'h10;
	localparam logic [15:0] CCS_CTRL_RESET = 16'h0000;
	localparam logic [15:0] CCS_STEP0_RESET = 16'h0000;
	localparam logic [15:0] CCS_READ_NONE = 16'h0000;

	// Command bit positions per channel, indexed A, B, sequencer
	localparam int CCS_GO_POS [CCS_NCHAN] = '{14, 12, 6};
	localparam int CCS_HALT_POS [CCS_NCHAN] = '{10, 8, 2};

	// Only the halt bits can ever read back as one
	localparam logic [15:0] CCS_CTRL_RMASK = 16'h0504;

	// Per-channel run state
	typedef enum logic [2:0] {
		CCS_IDLE = 3'b001,
		CCS_RUN = 3'b010,
		CCS_DRAIN = 3'b100
	} ccs_state_type;

	// Status coming back from one converter
	typedef struct packed {
		logic enable;
		logic single;
		logic done;
	} ccs_chan_in_type;

	// Decoded, accepted commands for one channel
	typedef struct packed {
		logic go;
		logic halt;
	} ccs_cmd_type;

	// One register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [CCS_ADDR_W-1:0] addr;
		logic [CCS_DATA_W-1:0] wdata;
	} ccs_reg_req_type;

	// Address match, used by both the write and the read paths
	function automatic logic ccs_hit(input logic [CCS_ADDR_W-1:0] addr,
		input logic [CCS_ADDR_W-1:0] offset);
		return addr == offset;
	endfunction

endpackage

/* core/ccs_result_reg.sv */
// Holding register for one sequence step result.
// Assumes load is a one-cycle strobe from the sequencer, data valid with it.
`timescale 1ns/1ps

module ccs_result_reg #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// New result
	input wire logic load_i,
	input wire logic [WIDTH-1:0] data_i,
	// Held value
	output logic [WIDTH-1:0] value_o
);

	logic [WIDTH-1:0] value_q;

	// Capture; the word is kept untouched, two's complement as delivered
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			value_q <= RESET_VALUE;
		end else if (load_i) begin
			value_q <= data_i;
		end
	end

	assign value_o = value_q;

endmodule // ccs_result_reg

/* test/ccs_conv_ctrl_tb.sv */
// Self-checking bench for the conversion start/stop block.
// Assumes the converter model answers only when the bench fires it.
`timescale 1ns/1ps

module ccs_conv_ctrl_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [1:0] en = 2'h0;
	logic [1:0] single = 2'h0;
	logic [2:0] fire = 3'h0;
	logic [15:0] step = 16'h0000;
	logic [15:0] rdata;
	logic rvalid;
	logic [2:0] go;
	logic [2:0] halt;
	logic [2:0] done;
	logic step_valid;
	logic [15:0] step_data;
	int error_cnt = 0;
	int samples_checked = 0;

	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end

	ccs_conv_ctrl dut (.CLOCK_I(clk), .RSTN_I(rstn), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.CONV_ENABLE_I(en), .CONV_SINGLE_I(single), .CONV_DONE_I(done[1:0]),
		.SEQ_DONE_I(done[2]), .STEP0_VALID_I(step_valid), .STEP0_DATA_I(step_data),
		.CONV_GO_O(go), .CONV_HALT_O(halt));

	ccs_conv_model model (.clk_i(clk), .go_i(go), .halt_i(halt), .fire_i(fire),
		.step_i(step), .done_o(done), .step_valid_o(step_valid), .step_o(step_data));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// commands only by writes
	// Write frame; pulses looked at in the cycle after the taking edge
	// An idle cycle follows so the next call never re-raises the strobe at once
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d, input logic [5:0] exp);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
		check({10'h000, halt, go}, {10'h000, exp});
		@(negedge clk);
	endtask

	// Read; answer registered on the taking edge and looked at on the falling edge half a cycle later
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		check({15'h0000, rvalid}, 16'h0001);
		check(rdata, exp);
		check({10'h000, halt, go}, 16'h0000);
		@(negedge clk);
	endtask

	// One completion from the selected units
	task automatic fire_done(input logic [2:0] m, input logic [15:0] v);
		fire = m;
		step = v;
		@(negedge clk);
		fire = 3'h0;
	endtask

	initial begin
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		// Reset values and an unmapped hole
		rd_reg(8'h09, 16'h0000);
		rd_reg(8'h10, 16'h0000);
		rd_reg(8'h20, 16'h0000);
		// Start refused while disabled, then taken
		wr_reg(8'h09, 16'h4000, 6'h00);
		en = 2'h3;
		wr_reg(8'h09, 16'h4000, 6'h01);
		rd_reg(8'h09, 16'h0000);
		wr_reg(8'h09, 16'h5040, 6'h07);
		// Stops pend until A and the sequencer finish; B's stop stays pending
		wr_reg(8'h09, 16'h0504, 6'h38);
		rd_reg(8'h09, 16'h0504);
		fire_done(3'h1, 16'h0000);
		rd_reg(8'h09, 16'h0104);
		fire_done(3'h4, 16'h8001);
		rd_reg(8'h09, 16'h0100);
		rd_reg(8'h10, 16'h8001);
		// Restart clears a pending stop
		wr_reg(8'h09, 16'h1000, 6'h02);
		rd_reg(8'h09, 16'h0000);
		// Start beats stop in one frame
		wr_reg(8'h09, 16'h5544, 6'h07);
		rd_reg(8'h09, 16'h0000);
		// Sequence stop then restart before the sequence finishes
		wr_reg(8'h09, 16'h0004, 6'h20);
		wr_reg(8'h09, 16'h0040, 6'h04);
		rd_reg(8'h09, 16'h0000);
		// Single-shot channel ignores stop
		single = 2'h3;
		wr_reg(8'h09, 16'h0500, 6'h00);
		rd_reg(8'h09, 16'h0000);
		// Single-shot B finishes and goes idle, so a later stop is refused
		fire_done(3'h2, 16'h0000);
		single = 2'h0;
		wr_reg(8'h09, 16'h0100, 6'h00);
		rd_reg(8'h09, 16'h0000);
		// Reserved bits and the read-only result
		wr_reg(8'h09, 16'haabb, 6'h00);
		rd_reg(8'h09, 16'h0000);
		wr_reg(8'h10, 16'hffff, 6'h00);
		rd_reg(8'h10, 16'h8001);
		// Reset in mid-run drops a pending stop and the result
		wr_reg(8'h09, 16'h0400, 6'h08);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		rd_reg(8'h09, 16'h0000);
		rd_reg(8'h10, 16'h0000);
		final_report();
	end
endmodule // ccs_conv_ctrl_tb

/* test/ccs_conv_model.sv */
// Behavioural converters and sequencer facing the start/stop block.
// Assumes the bench asks for each completion through fire_i, off the falling edge.
`timescale 1ns/1ps

module ccs_conv_model (
	// Clock
	input wire logic clk_i,
	// Requests from the block, completion asks from the bench
	input wire logic [2:0] go_i,
	input wire logic [2:0] halt_i,
	input wire logic [2:0] fire_i,
	input wire logic [15:0] step_i,
	// Completions toward the block
	output logic [2:0] done_o,
	output logic step_valid_o,
	output logic [15:0] step_o
);
	logic [2:0] run_q = 3'h0;
	logic [2:0] stop_q = 3'h0;

	// Run and stop tracking; a stopped converter still finishes its current job
	always @(posedge clk_i) begin
		run_q <= (run_q | go_i) & ~(done_o & stop_q);
		stop_q <= (stop_q | halt_i) & ~go_i & ~done_o;
	end

	// Completion only from a running unit; data line scrambled when not valid
	assign done_o = fire_i & run_q;
	assign step_valid_o = done_o[2];
	assign step_o = step_valid_o ? step_i : ~step_i;
endmodule // ccs_conv_model
